// [logic/fault_if.sv]
/*
 * Carrier between the handler block and its fault pulse timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface fault_if;
    logic start; // one-cycle request to begin a pulse
    logic active; // high while the pulse runs
    modport owner (output start, input active);
    modport timer (input start, output active);
endinterface : fault_if

`default_nettype wire

// [logic/fault_timer.sv]
/*
 * Fault pulse timer: a start request opens a window of CYCLES clocks.
 * Assumes clock enable gating and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module fault_timer
    import handler_pkg::*;
#(
    parameter int CYCLES = FAULT_PULSE_CYC
) (
    input wire logic clock, // system clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable
    fault_if.timer fi // start in, active out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic active;
    } tmr_state_t;

    tmr_state_t s_reg;
    tmr_state_t s_next;

    // -------------------------------------------------------------
    // countdown
    // -------------------------------------------------------------
    // a new failure restarts the window so the pulse never cuts short
    always_comb begin
        s_next = s_reg;
        if (fi.start) begin
            s_next.cnt = LOAD;
            s_next.active = 1'b1;
        end else if (s_reg.cnt > CW'(1)) begin
            s_next.cnt = s_reg.cnt - CW'(1);
        end else begin
            s_next.cnt = '0;
            s_next.active = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign fi.active = s_reg.active;

endmodule : fault_timer

`default_nettype wire

// [logic/handler_io.sv]
/*
 * Handler interface logic of a four-channel resistance meter: start
 * qualification, measurement sequencing, negative-true result lines,
 * keyboard lockout, power-on self-test outcome, fault pulse and an
 * Avalon-MM register slave with a level interrupt.
 * Assumes the measurement engine, key scanner and self-test engine sit
 * outside and hand over one-cycle pulses synchronous to clock.
 */
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module handler_io
    import handler_pkg::*;
#(
    parameter int FAULT_CYCLES = FAULT_PULSE_CYC
) (
    input wire logic clock, // 200 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable, freezes all state
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address, // byte address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [31:0] writedata, // write data
    output logic [31:0] readdata, // read data
    output logic waitrequest, // stall
    output logic irq, // level interrupt
    // handler pins
    input wire logic external_start_pulse_n, // start, active low
    input wire logic panel_lockout_n, // key lockout, active low
    output logic [NCH-1:0] above_limit_n, // high result
    output logic [NCH-1:0] pass_band_n, // in result
    output logic [NCH-1:0] under_limit_n, // low result
    output logic [NCH-1:0] probe_touch_fail_n, // contact failed
    output logic analog_done_n, // analog part complete
    output logic result_valid_n, // results valid
    output logic fault_pulse_n, // power failure notice
    // measurement engine
    output logic meas_start, // one-cycle start request
    input wire logic analog_done_in, // analog part finished, pulse
    input wire logic compute_done_in, // results ready, pulse
    input wire logic [2*NCH-1:0] meas_code, // 2 bits per channel
    input wire logic [NCH-1:0] contact_fail, // per-channel contact fail
    input wire logic power_fail, // momentary power failure, pulse
    input wire logic halt_error, // fatal error, pulse
    // self-test engine
    input wire logic st_done_in, // power-on test finished, pulse
    input wire logic [ST_W-1:0] st_fail, // failing item bits
    output logic load_defaults, // one-cycle load of default data
    // front panel
    input wire logic key_valid, // key pressed
    output logic key_accept // key may act
);

    top_state_t s_reg;
    top_state_t s_next;
    fault_if fi ();

    // -------------------------------------------------------------
    // fault pulse timer
    // -------------------------------------------------------------
    fault_timer #(
        .CYCLES(FAULT_CYCLES)
    ) u_fault (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .fi(fi)
    );

    // -------------------------------------------------------------
    // per-channel decode of the comparison code
    // -------------------------------------------------------------
    logic [NCH-1:0] dec_hi;
    logic [NCH-1:0] dec_in;
    logic [NCH-1:0] dec_lo;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic [1:0] code;
            assign code = meas_code[2*ch +: 2];
            assign dec_hi[ch] = (code == CMP_HIGH);
            assign dec_in[ch] = (code == CMP_IN);
            assign dec_lo[ch] = (code == CMP_LOW);
        end
    endgenerate

    // -------------------------------------------------------------
    // bus decode helpers
    // -------------------------------------------------------------
    logic bus_req;
    logic wr_fire;
    logic rd_first;
    logic halted;
    logic start_edge;
    logic sw_trig;
    logic trig;
    logic [31:0] rd_mux;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign bus_req = read | write;
    assign wr_fire = write & s_reg.ack;
    assign rd_first = read & ~s_reg.ack;
    assign halted = (s_reg.phase == ST_HALT);

    // rising edge after a low phase of the guaranteed width
    assign start_edge = external_start_pulse_n & ~s_reg.start_d
        & (s_reg.low_cnt >= LOW_CNT_W'(EXT_MIN_LOW_CYC));
    assign sw_trig = wr_fire && (address == OFS_CTRL)
        && writedata[CTRL_SW_TRIG];
    assign trig = s_reg.trig_ext ? start_edge : sw_trig;

    // read data, unmapped offsets answer zero
    always_comb begin
        rd_mux = '0;
        case (address)
            OFS_CTRL: begin
                rd_mux[CTRL_TRIG_EXT] = s_reg.trig_ext;
                rd_mux[CTRL_CMP_EN] = s_reg.cmp_en;
            end
            OFS_STATUS: begin
                rd_mux[0] = s_reg.result_valid;
                rd_mux[1] = s_reg.analog_done;
                rd_mux[2] = s_reg.st_done;
                rd_mux[3] = ~panel_lockout_n;
                rd_mux[4] = (s_reg.phase == ST_ANALOG)
                    | (s_reg.phase == ST_COMPUTE);
                rd_mux[5] = halted;
            end
            OFS_IRQ_ST: rd_mux[IRQ_W-1:0] = s_reg.irq_st;
            OFS_IRQ_MSK: rd_mux[IRQ_W-1:0] = s_reg.irq_msk;
            OFS_RESULT: begin
                rd_mux[4*NCH-1:0] = {s_reg.nc, s_reg.lo, s_reg.inb,
                    s_reg.hi};
            end
            OFS_SELFTEST: rd_mux[ST_W-1:0] = s_reg.st_code;
            default: rd_mux = '0;
        endcase
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.meas_start = 1'b0;
        s_next.load_def = 1'b0;
        irq_set = '0;
        irq_clr = '0;

        // start pin watch; count saturates to keep the width honest
        s_next.start_d = external_start_pulse_n;
        if (external_start_pulse_n) begin
            s_next.low_cnt = '0;
        end else if (s_reg.low_cnt != '1) begin
            s_next.low_cnt = s_reg.low_cnt + LOW_CNT_W'(1);
        end

        // one wait state, then the answer
        s_next.ack = bus_req & ~s_reg.ack;
        if (rd_first) begin
            s_next.rdata = rd_mux;
        end
        if (wr_fire) begin
            case (address)
                OFS_CTRL: begin
                    s_next.trig_ext = writedata[CTRL_TRIG_EXT];
                    s_next.cmp_en = writedata[CTRL_CMP_EN];
                end
                OFS_IRQ_ST: irq_clr = writedata[IRQ_W-1:0];
                OFS_IRQ_MSK: s_next.irq_msk = writedata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // measurement sequence
        case (s_reg.phase)
            ST_SELFTEST: begin
                // settings registers are never written from here
                if (st_done_in) begin
                    s_next.st_code = st_fail;
                    s_next.st_done = 1'b1;
                    if ((st_fail & ST_CRIT_MASK) != '0) begin
                        s_next.phase = ST_HALT;
                    end else begin
                        s_next.load_def =
                            ((st_fail & ST_SOFT_MASK) != '0);
                        s_next.phase = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (trig) begin
                    s_next.meas_start = 1'b1;
                    s_next.analog_done = 1'b0;
                    s_next.result_valid = 1'b0;
                    s_next.phase = ST_ANALOG;
                end
            end
            ST_ANALOG: begin
                if (analog_done_in) begin
                    s_next.analog_done = 1'b1;
                    irq_set[IRQ_ANALOG] = 1'b1;
                    s_next.phase = ST_COMPUTE;
                end
            end
            ST_COMPUTE: begin
                // results latch only together with result valid
                if (compute_done_in) begin
                    s_next.hi = dec_hi;
                    s_next.inb = dec_in;
                    s_next.lo = dec_lo;
                    s_next.nc = contact_fail;
                    s_next.result_valid = 1'b1;
                    irq_set[IRQ_RESULT] = 1'b1;
                    s_next.phase = ST_IDLE;
                end
            end
            ST_HALT: ; // left only by reset; start edges ignored
            default: s_next.phase = ST_HALT;
        endcase

        if (halt_error && !halted) begin
            s_next.phase = ST_HALT;
            s_next.meas_start = 1'b0;
        end
        if (s_next.phase == ST_HALT && !halted) begin
            irq_set[IRQ_HALT] = 1'b1;
        end
        irq_set[IRQ_POWER] = power_fail;

        // sticky status, a fresh event wins over the clear
        s_next.irq_st = (s_reg.irq_st & ~irq_clr) | irq_set;

        // pin drivers: low is asserted, all released with comparator
        // off; while halted all but the fault line keep their last state
        if (!halted) begin
            if (s_reg.cmp_en) begin
                s_next.hi_n = ~s_reg.hi;
                s_next.in_n = ~s_reg.inb;
                s_next.lo_n = ~s_reg.lo;
                s_next.nc_n = ~s_reg.nc;
                s_next.analog_n = ~s_reg.analog_done;
                s_next.valid_n = ~s_reg.result_valid;
            end else begin
                s_next.hi_n = '1;
                s_next.in_n = '1;
                s_next.lo_n = '1;
                s_next.nc_n = '1;
                s_next.analog_n = 1'b1;
                s_next.valid_n = 1'b1;
            end
        end
        s_next.fault_n = ~(s_reg.cmp_en & fi.active);
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    // settings take reset values only here, never from the self-test
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.phase <= ST_SELFTEST;
            s_reg.start_d <= 1'b1;
            s_reg.trig_ext <= CTRL_TRIG_EXT_RST;
            s_reg.cmp_en <= CTRL_CMP_EN_RST;
            s_reg.hi_n <= '1;
            s_reg.in_n <= '1;
            s_reg.lo_n <= '1;
            s_reg.nc_n <= '1;
            s_reg.analog_n <= 1'b1;
            s_reg.valid_n <= 1'b1;
            s_reg.fault_n <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    // a power failure starts the timer; a halt does not cut it short
    assign fi.start = ce & power_fail;

    assign waitrequest = bus_req & ~s_reg.ack;
    assign readdata = s_reg.rdata;
    assign irq = |(s_reg.irq_st & s_reg.irq_msk);

    assign above_limit_n = s_reg.hi_n;
    assign pass_band_n = s_reg.in_n;
    assign under_limit_n = s_reg.lo_n;
    assign probe_touch_fail_n = s_reg.nc_n;
    assign analog_done_n = s_reg.analog_n;
    assign result_valid_n = s_reg.valid_n;
    assign fault_pulse_n = s_reg.fault_n;
    assign meas_start = s_reg.meas_start;
    assign load_defaults = s_reg.load_def;

    // keys pass only with the lockout line released
    assign key_accept = key_valid & panel_lockout_n;

endmodule : handler_io

`default_nettype wire

// [logic/handler_pkg.sv]
/*
 * Shared constants and types for the handler signalling block: register
 * map, field positions, reset values, result codes, timing counts.
 * Assumes a 200 MHz system clock and an Avalon-MM register bus.
 */

package handler_pkg;

    // -------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int EXT_MIN_LOW_NS = 1000;
    localparam int EXT_MIN_LOW_CYC =
        (EXT_MIN_LOW_NS * CLOCK_MHZ + 999) / 1000;
    localparam int FAULT_PULSE_MS = 200;
    localparam int FAULT_PULSE_CYC = FAULT_PULSE_MS * CLOCK_MHZ * 1000;
    localparam int LOW_CNT_W = 8;

    // -------------------------------------------------------------
    // register map (byte offsets)
    // -------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_SELFTEST = 5'h14;

    // control fields
    localparam int CTRL_TRIG_EXT = 0;
    localparam int CTRL_CMP_EN = 1;
    localparam int CTRL_SW_TRIG = 2;
    localparam logic CTRL_TRIG_EXT_RST = 1'b0;
    localparam logic CTRL_CMP_EN_RST = 1'b0;

    // interrupt fields
    localparam int IRQ_W = 4;
    localparam int IRQ_ANALOG = 0;
    localparam int IRQ_RESULT = 1;
    localparam int IRQ_POWER = 2;
    localparam int IRQ_HALT = 3;

    // self-test items: ram 1, rom 2, cal 4, user 8, a/d 16, backup 32
    localparam int ST_W = 6;
    localparam logic [ST_W-1:0] ST_CRIT_MASK = 6'h17;
    localparam logic [ST_W-1:0] ST_SOFT_MASK = 6'h28;

    // per-channel comparison codes
    localparam int NCH = 4;
    localparam logic [1:0] CMP_NONE = 2'h0;
    localparam logic [1:0] CMP_HIGH = 2'h1;
    localparam logic [1:0] CMP_IN = 2'h2;
    localparam logic [1:0] CMP_LOW = 2'h3;

    typedef enum logic [2:0] {
        ST_SELFTEST,
        ST_IDLE,
        ST_ANALOG,
        ST_COMPUTE,
        ST_HALT
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic start_d;
        logic [LOW_CNT_W-1:0] low_cnt;
        logic trig_ext;
        logic cmp_en;
        logic ack;
        logic [31:0] rdata;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_msk;
        logic [NCH-1:0] hi;
        logic [NCH-1:0] inb;
        logic [NCH-1:0] lo;
        logic [NCH-1:0] nc;
        logic analog_done;
        logic result_valid;
        logic [ST_W-1:0] st_code;
        logic st_done;
        logic meas_start;
        logic load_def;
        logic [NCH-1:0] hi_n;
        logic [NCH-1:0] in_n;
        logic [NCH-1:0] lo_n;
        logic [NCH-1:0] nc_n;
        logic analog_n;
        logic valid_n;
        logic fault_n;
    } top_state_t;

endpackage : handler_pkg

// [tb/handler_io_assertions.sv]
/*
 * Port checker for handler_io.
 * Assumes ce held high; attached by bind to every handler_io.
 */
`timescale 1ns/10ps
`default_nettype none

module handler_io_assertions
    import handler_pkg::*;
#(
    parameter int FAULT_CYCLES = FAULT_PULSE_CYC
) (
    input wire logic clock, // system clock
    input wire logic rst, // async reset
    input wire logic read, // bus read
    input wire logic write, // bus write
    input wire logic waitrequest, // bus stall
    input wire logic external_start_pulse_n, // start line
    input wire logic panel_lockout_n, // lockout line
    input wire logic [NCH-1:0] above_limit_n, // high result
    input wire logic [NCH-1:0] pass_band_n, // in result
    input wire logic [NCH-1:0] under_limit_n, // low result
    input wire logic [NCH-1:0] probe_touch_fail_n, // contact failed
    input wire logic analog_done_n, // analog done pin
    input wire logic result_valid_n, // result valid pin
    input wire logic fault_pulse_n, // fault pin
    input wire logic meas_start, // start request
    input wire logic analog_done_in, // analog finished
    input wire logic compute_done_in, // results ready
    input wire logic [2*NCH-1:0] meas_code, // comparison codes
    input wire logic [NCH-1:0] contact_fail, // contact per channel
    input wire logic power_fail, // power failure
    input wire logic halt_error, // fatal error
    input wire logic st_done_in, // self-test finished
    input wire logic [ST_W-1:0] st_fail, // failing items
    input wire logic load_defaults, // default load
    input wire logic key_valid, // key pressed
    input wire logic key_accept // key may act
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [8:0] low_cnt;
    logic [31:0] flt_run;
    logic halted;
    logic [NCH-1:0] hi_x;
    logic [NCH-1:0] in_x;
    logic [NCH-1:0] lo_x;

    // -----------------------------------------------------------------
    // helper logic
    // -----------------------------------------------------------------
    // expected line per channel, decoded apart from the design
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            hi_x[i] = meas_code[2*i +: 2] == CMP_HIGH;
            in_x[i] = meas_code[2*i +: 2] == CMP_IN;
            lo_x[i] = meas_code[2*i +: 2] == CMP_LOW;
        end
    end

    // start pin low run, saturating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_cnt <= 9'h000;
            flt_run <= 32'h0;
            halted <= 1'b0;
        end else begin
            if (external_start_pulse_n) low_cnt <= 9'h000;
            else if (low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h001;
            flt_run <= fault_pulse_n ? 32'h0 : flt_run + 32'h1;
            halted <= halted | halt_error
                | (st_done_in & |(st_fail & ST_CRIT_MASK));
        end
    end

    AST_START_EDGE:
    assert property (meas_start |-> $past(external_start_pulse_n)
        && $past(low_cnt) >= EXT_MIN_LOW_CYC)
        else $error("short start taken");
    AST_RESULTS:
    assert property ($fell(result_valid_n) && $past(compute_done_in, 2)
        |-> above_limit_n == ~$past(hi_x, 2)
        && pass_band_n == ~$past(in_x, 2)
        && under_limit_n == ~$past(lo_x, 2)
        && probe_touch_fail_n == ~$past(contact_fail, 2))
        else $error("result lines wrong");
    AST_KEY_LOCK:
    assert property (key_accept == (key_valid && panel_lockout_n))
        else $error("key accepted under lockout");
    AST_ANALOG:
    assert property ($fell(analog_done_n)
        |-> $past(analog_done_in, 2) || $past(write, 2))
        else $error("stray analog done");
    AST_VALID_CAUSE:
    assert property ($fell(result_valid_n)
        |-> $past(compute_done_in, 2) || $past(write, 2))
        else $error("stray result valid");
    AST_VALID_HOLD:
    assert property (!result_valid_n && $past(!result_valid_n)
        |-> $stable({above_limit_n, pass_band_n, under_limit_n}))
        else $error("results moved");
    AST_FAULT_CAUSE:
    assert property ($fell(fault_pulse_n) |-> $past(power_fail, 2))
        else $error("stray fault pulse");
    AST_FAULT_LEN:
    assert property ($rose(fault_pulse_n) |-> flt_run == FAULT_CYCLES)
        else $error("fault pulse length wrong");
    AST_HALT_HOLD:
    assert property ($past(halted) |-> !meas_start
        && $stable({above_limit_n, pass_band_n, under_limit_n}))
        else $error("halt not held");
    AST_LOAD_DEF:
    assert property (st_done_in && (st_fail & ST_CRIT_MASK) == '0
        && (st_fail & ST_SOFT_MASK) != '0 |=> load_defaults)
        else $error("defaults not loaded");
    AST_BUS_WAIT:
    assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("wait state wrong");

    COV_RESULT: cover property ($fell(result_valid_n));
    COV_FAULT: cover property ($rose(fault_pulse_n));
    COV_START: cover property (meas_start);
endmodule : handler_io_assertions

bind handler_io handler_io_assertions #(.FAULT_CYCLES(FAULT_CYCLES)) chk (.*);

`default_nettype wire

// [tb/handler_model.sv]
/*
 * Handler model: start and lockout lines.
 * Assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module handler_model (
    input wire logic clock, // system clock
    output logic external_start_pulse_n, // start line, active low
    output logic panel_lockout_n // lockout line, active low
);
    // lines idle high, as the pull-ups leave them
    initial begin
        external_start_pulse_n = 1'b1;
        panel_lockout_n = 1'b1;
    end

    // low phase of the given length, ends with the rising edge
    task automatic start_pulse(input int low_cycles);
        external_start_pulse_n <= 1'b0;
        repeat (low_cycles) @(posedge clock);
        external_start_pulse_n <= 1'b1;
    endtask : start_pulse

    // level held until changed again
    task automatic lock(input logic on);
        panel_lockout_n <= !on;
    endtask : lock
endmodule : handler_model

`default_nettype wire

// [tb/tb_handler_io.sv]
/*
 * Bench for handler_io: self-test, lockout and short-start cases, table of measurements, then odd cases.
 * Assumes handler_model on the handler inputs.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_handler_io;
    import handler_pkg::*;
    localparam int FCYC = 50;
    typedef struct packed {
        logic [7:0] code;
        logic [3:0] cf;
        logic [15:0] exp; // above, pass, under, probe
    } row_t;
    row_t rows [5] = '{'{8'he4, 4'h0, 16'hdb7f}, '{8'h1b, 4'ha, 16'hbde5},
        '{8'h55, 4'hf, 16'h0ff0}, '{8'haa, 4'h0, 16'hf0ff},
        '{8'hff, 4'h5, 16'hff0a}};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic read, write, analog_done_in, compute_done_in, power_fail;
    logic halt_error, st_done_in, key_valid;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0;
    logic [7:0] meas_code = 8'h00;
    logic [3:0] contact_fail = 4'h0;
    logic [5:0] st_fail = 6'h00;
    logic [31:0] readdata, q;
    logic waitrequest, irq, analog_done_n, result_valid_n, fault_pulse_n;
    logic meas_start, load_defaults, key_accept, external_start_pulse_n;
    logic panel_lockout_n;
    logic [3:0] above_limit_n, pass_band_n, under_limit_n, probe_touch_fail_n;
    logic [15:0] pins;
    int error_cnt = 0;
    int total_checks = 0;
    int n;

    assign pins = {above_limit_n, pass_band_n, under_limit_n,
        probe_touch_fail_n};
    always #2.5 clock = ~clock;

    handler_model hm (.*);
    handler_io #(.FAULT_CYCLES(FCYC)) uut (.ce(1'b1), .*);

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // request held until waitrequest is sampled low, one idle edge after
    task automatic bus(input logic wr, input logic [4:0] a,
            input logic [31:0] d, output logic [31:0] r);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask : bus

    // one full measurement with pin and register checks
    task automatic measure(input row_t r, input int width, input logic go,
            input logic cmp);
        logic got;
        hm.start_pulse(width);
        got = 1'b0;
        repeat (8) begin
            @(posedge clock);
            got |= (meas_start === 1'b1);
        end
        check(got, go);
        if (go) begin
            analog_done_in <= 1'b1;
            @(posedge clock);
            analog_done_in <= 1'b0;
            repeat (2) @(posedge clock);
            check(analog_done_n, !cmp);
            check(result_valid_n, 1'b1);
            meas_code <= r.code;
            contact_fail <= r.cf;
            compute_done_in <= 1'b1;
            @(posedge clock);
            compute_done_in <= 1'b0;
            repeat (2) @(posedge clock);
            check(result_valid_n, !cmp);
            check(pins, cmp ? r.exp : 16'hffff);
            bus(1'b0, OFS_RESULT, 32'h0, q);
            check(q, {16'h0, ~{r.exp[3:0], r.exp[7:4], r.exp[11:8],
                r.exp[15:12]}});
        end
    endtask : measure

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        {read, write, analog_done_in, compute_done_in, power_fail,
            halt_error, st_done_in, key_valid} <= '0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({pins, analog_done_n, result_valid_n}, 18'h3ffff);
        bus(1'b0, OFS_CTRL, 32'h0, q);
        check(q, 32'h0);
        // setting written before self-test ends must survive it
        bus(1'b1, OFS_CTRL, 32'h1, q);
        st_fail <= 6'h08;
        st_done_in <= 1'b1;
        @(posedge clock);
        st_done_in <= 1'b0;
        @(posedge clock);
        check(load_defaults, 1'b1);
        bus(1'b0, OFS_CTRL, 32'h0, q);
        check(q, 32'h1);
        bus(1'b0, OFS_SELFTEST, 32'h0, q);
        check(q, 32'h8);
        hm.lock(1'b1);
        key_valid <= 1'b1;
        @(posedge clock);
        check(key_accept, 1'b0);
        hm.lock(1'b0);
        @(posedge clock);
        check(key_accept, 1'b1);
        measure(rows[0], 150, 1'b0, 1'b1);
        measure(rows[0], 210, 1'b1, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h3, q);
        @(posedge clock);
        check(pins, rows[0].exp);
        for (int i = 0; i < 5; i++) begin
            measure(rows[i], 210, 1'b1, 1'b1);
        end
        // result done bit masked, unmasked, cleared
        check(irq, 1'b0);
        bus(1'b1, OFS_IRQ_MSK, 32'h2, q);
        check(irq, 1'b1);
        bus(1'b1, OFS_IRQ_ST, 32'h2, q);
        check(irq, 1'b0);
        bus(1'b0, 5'h1c, 32'h0, q);
        check(q, 32'h0);
        power_fail <= 1'b1;
        @(posedge clock);
        power_fail <= 1'b0;
        repeat (2) @(posedge clock);
        n = 0;
        while (fault_pulse_n === 1'b0 && n < 2 * FCYC) begin
            n++;
            @(posedge clock);
        end
        check(n, FCYC);
        bus(1'b0, OFS_IRQ_ST, 32'h0, q);
        check(q, 32'h5);
        halt_error <= 1'b1;
        @(posedge clock);
        halt_error <= 1'b0;
        @(posedge clock);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        check(q[5], 1'b1);
        measure(rows[1], 210, 1'b0, 1'b1);
        check(pins, rows[4].exp);
        test_done();
    end

    // watchdog, far past the run's length
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule : tb_handler_io

`default_nettype wire
